// ===== pkg/sapr_cfg.svh
// Timing counts and widths of the converter control block
`ifndef SAPR_CFG_SVH
`define SAPR_CFG_SVH
`define SAPR_RES_W 14
`define SAPR_CLK_MHZ 25
`define SAPR_CONV_NS 4700
// Longest time rounds down
`define SAPR_CONV_CYC ((`SAPR_CONV_NS * `SAPR_CLK_MHZ) / 1000)
`define SAPR_SAR_STEPS 14
`define SAPR_FIFO_DEPTH 8
`define SAPR_FIFO_AW 3
`define SAPR_MSB_FLIP 14'h2000
`endif

// ===== pkg/sapr_pkg.sv
// Types of the converter control block
package sapr_pkg;
	typedef enum logic [5:0] {
		SAPR_IDLE = 6'h01,
		SAPR_ACQ = 6'h02,
		SAPR_CONV = 6'h04,
		SAPR_DONE = 6'h08,
		SAPR_READ = 6'h10,
		SAPR_WAIT = 6'h20
	} sapr_state_t;
	typedef struct packed {
		logic [13:0] data;
		logic oe;
	} sapr_bus_t;
endpackage

// ===== logic/sapr_top.sv
// Control, conversion timing and result bus of the SAR converter
`timescale 1ns/10ps
`include "sapr_cfg.svh"
// Overview of operation
// - Select level at second strobe fall picks the power-down mode after conversion.
// - Select low at second fall: standby, reference and buffer stay powered.
// - Select high at second fall: shutdown, reference and buffer power off.
// - In standby, strobe fall with select low starts acquisition at once.
// - In shutdown, strobe fall with select low wakes reference, enters acquisition.
// - End-of-conversion flag goes low when a conversion finishes.
// - Result bus stays high impedance during acquisition and conversion.
// - Third strobe fall with select high drives the result onto the bus.
// - Strobe returning high releases the result bus.
// - After release the device idles until the next strobe fall.
// - Result is a 14-bit word, least significant bit on line zero.
// - Two's complement (MSB inverted) for bipolar variants, straight binary for unipolar.
// - Conversion ends and flag asserts within 4.7 us of second fall.
// - First strobe fall with select low powers up, starts acquisition; high ignored.
// - Second strobe fall ends acquisition, holds sample, starts conversion.
// - Reset with strobe high returns sequence to idle.
module sapr_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign in_ready = cnt_q != DEPTH[AW:0];
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rd_q];
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule

module sapr_top
	import sapr_pkg::*;
#(
	parameter logic BIPOLAR = 1'b1
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic strobe_n,
	input wire logic read_sel,
	input wire logic [13:0] sample_code,
	output logic eoc_n,
	output logic [13:0] result_bus_o,
	output logic [13:0] result_bus_oe,
	output logic ref_on,
	output logic track,
	output logic conv_busy
);
	localparam logic [12:0] CONV_CYC = 13'(`SAPR_CONV_CYC);
	localparam logic [12:0] STEP_CYC = 13'(`SAPR_CONV_CYC / `SAPR_SAR_STEPS);
	sapr_state_t state_q;
	logic strobe_q;
	logic fall;
	logic rise;
	logic shutdown_q;
	logic [12:0] tmr_q;
	logic [13:0] sample_q;
	logic [13:0] sar_q;
	logic [3:0] bit_q;
	logic [13:0] rd_data;
	logic rd_valid;
	logic rd_take;
	logic wr_ready;
	logic push_q;
	logic [13:0] push_data_q;
	logic conv_go;
	logic wake_go;
	logic step_end;
	logic last_bit;
	logic over;
	logic [13:0] final_code;
	sapr_bus_t bus_q;
	// Output coding for the input range variant
	function automatic logic [13:0] code_out(input logic [13:0] raw);
		code_out = BIPOLAR ? (raw ^ `SAPR_MSB_FLIP) : raw;
	endfunction
	assign fall = strobe_q && !strobe_n;
	assign rise = !strobe_q && strobe_n;
	assign rd_take = (state_q == SAPR_DONE) && fall && read_sel && rd_valid;
	// Second strobe fall; held off while the buffer is full so no word is lost
	assign conv_go = (state_q == SAPR_ACQ) && fall && wr_ready;
	// Acquisition request from idle or straight after a finished conversion
	assign wake_go = (state_q == SAPR_IDLE || state_q == SAPR_DONE) && fall && !read_sel;
	// Trial word above the held sample: the current bit is dropped
	assign over = sar_q > sample_q;
	// Second term is only a backstop; steps end long before the limit
	assign step_end = (tmr_q == STEP_CYC - 13'h0001) || (tmr_q == CONV_CYC - 13'h0001);
	assign last_bit = bit_q == 4'h0;
	assign final_code = over ? (sar_q & ~14'h0001) : sar_q;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			strobe_q <= 1'b1;
		end else begin
			strobe_q <= strobe_n;
		end
	end
	// Sequencer; conversion stalls if the result buffer is full
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q <= SAPR_IDLE;
		end else begin
			unique case (state_q)
				SAPR_IDLE: begin
					if (fall && !read_sel) begin
						state_q <= SAPR_ACQ;
					end
				end
				SAPR_ACQ: begin
					// Select level is free here; it only picks the power mode
					if (conv_go) begin
						state_q <= SAPR_CONV;
					end
				end
				SAPR_CONV: begin
					if (push_q) begin
						state_q <= SAPR_DONE;
					end
				end
				SAPR_DONE: begin
					if (rd_take) begin
						state_q <= SAPR_READ;
					end else if (fall && !read_sel) begin
						state_q <= SAPR_ACQ;
					end
				end
				SAPR_READ: begin
					if (rise) begin
						state_q <= SAPR_IDLE;
					end
				end
				default: begin
					state_q <= SAPR_IDLE;
				end
			endcase
		end
	end
	// Power mode latched at the conversion-start edge
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			shutdown_q <= 1'b1;
			ref_on <= 1'b0;
		end else begin
			if (conv_go) begin
				shutdown_q <= read_sel;
			end
			if (wake_go) begin
				ref_on <= 1'b1;
			end else if (push_q && shutdown_q) begin
				ref_on <= 1'b0;
			end else if (push_q) begin
				ref_on <= 1'b1;
			end
		end
	end
	// Step timer of the internal conversion clock
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tmr_q <= '0;
		end else if (conv_go) begin
			tmr_q <= '0;
		end else if (state_q == SAPR_CONV && !push_q) begin
			if (step_end) begin
				tmr_q <= '0;
			end else begin
				tmr_q <= tmr_q + 13'h0001;
			end
		end
	end
	// Bit-serial SAR against the held sample, one bit per step
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bit_q <= '0;
			sar_q <= '0;
			sample_q <= '0;
			push_q <= 1'b0;
			push_data_q <= '0;
		end else begin
			push_q <= 1'b0;
			if (conv_go) begin
				sample_q <= sample_code;
				bit_q <= 4'hD;
				sar_q <= 14'h2000;
			end else if (state_q == SAPR_CONV && !push_q && step_end) begin
				if (over) begin
					sar_q[bit_q] <= 1'b0;
				end
				if (!last_bit) begin
					sar_q[bit_q - 4'h1] <= 1'b1;
					bit_q <= bit_q - 4'h1;
				end else begin
					push_q <= 1'b1;
					push_data_q <= code_out(final_code);
				end
			end
		end
	end
	sapr_fifo #(
		.WIDTH(`SAPR_RES_W),
		.DEPTH(`SAPR_FIFO_DEPTH),
		.AW(`SAPR_FIFO_AW)
	) u_fifo (
		.sys_clk(sys_clk),
		.reset(reset),
		.in_data(push_data_q),
		.in_valid(push_q),
		.in_ready(wr_ready),
		.out_data(rd_data),
		.out_valid(rd_valid),
		.out_ready(rd_take)
	);
	// Flag and bus drive
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			eoc_n <= 1'b1;
			bus_q <= '0;
		end else begin
			if (push_q) begin
				eoc_n <= 1'b0;
			end else if (fall) begin
				eoc_n <= 1'b1;
			end
			if (rd_take) begin
				bus_q.data <= rd_data;
				bus_q.oe <= 1'b1;
			end else if (rise || state_q != SAPR_READ) begin
				bus_q.oe <= 1'b0;
			end
		end
	end
	// Enable drops on the rising strobe itself, at the same edge as the state leaves read
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			result_bus_o <= '0;
			result_bus_oe <= '0;
		end else begin
			result_bus_o <= bus_q.data;
			result_bus_oe <= {14{bus_q.oe && !rise}};
		end
	end
	// Phase flags
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			track <= 1'b0;
			conv_busy <= 1'b0;
		end else begin
			track <= state_q == SAPR_ACQ;
			conv_busy <= state_q == SAPR_CONV;
		end
	end
endmodule

// ===== tb/sapr_host.sv
// Host model that drives strobe and select and reads the bus
`timescale 1ns/10ps
module sapr_host(
	input wire logic sys_clk,
	input wire logic [13:0] result_bus_o,
	input wire logic [13:0] result_bus_oe,
	output logic strobe_n,
	output logic read_sel,
	output logic [13:0] bus_w
);
	logic [13:0] last_q = 14'h0;
	initial begin
		strobe_n = 1'b1;
		read_sel = 1'b0;
	end
	// Released bus toggles so a stale value never reads as valid
	always @(posedge sys_clk) last_q <= bus_w;
	assign bus_w = result_bus_oe[0] ? result_bus_o : ~last_q;
	task automatic pulse(input logic sel, input int n);
		@(posedge sys_clk);
		strobe_n <= 1'b0;
		read_sel <= sel;
		repeat (n) @(posedge sys_clk);
		strobe_n <= 1'b1;
		@(posedge sys_clk);
		#1;
	endtask
endmodule

// ===== tb/sapr_assertions.sv
// Port checks of the converter block
`timescale 1ns/10ps
module sapr_chk(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic strobe_n,
	input wire logic read_sel,
	input wire logic eoc_n,
	input wire logic [13:0] result_bus_oe,
	input wire logic ref_on,
	input wire logic track,
	input wire logic conv_busy
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence s_conv(b);
		$fell(strobe_n) && track && read_sel == b;
	endsequence
	sequence s_read;
		$fell(strobe_n) && !eoc_n && read_sel;
	endsequence
	a_bus_quiet: assert property ((track || conv_busy) |-> !result_bus_oe) else $error("bus early");
	a_stby_ref: assert property (s_conv(0) |-> ##[1:122] (!eoc_n && ref_on)) else $error("standby");
	a_shdn_ref: assert property (s_conv(1) |-> ##[1:122] (!eoc_n && !ref_on)) else $error("shutdown");
	a_read_drive: assert property (s_read |-> ##[1:2] &result_bus_oe) else $error("no drive");
	a_bus_free: assert property ($rose(strobe_n) |-> ##[1:2] !result_bus_oe) else $error("no release");
	a_oe_whole: assert property (!result_bus_oe || &result_bus_oe) else $error("split");
	a_eoc_stand: assert property (!eoc_n && strobe_n |=> !eoc_n) else $error("eoc lost");
	a_idle_skip: assert property ($fell(strobe_n) && read_sel && eoc_n && !track && !conv_busy |=> ##1 !track)
		else $error("idle start");
	a_reset_idle: assert property (disable iff (1'b0) reset |=> eoc_n && !result_bus_oe && !ref_on)
		else $error("reset");
endmodule
bind sapr_top sapr_chk u_chk(
	.sys_clk(sys_clk),
	.reset(reset),
	.strobe_n(strobe_n),
	.read_sel(read_sel),
	.eoc_n(eoc_n),
	.result_bus_oe(result_bus_oe),
	.ref_on(ref_on),
	.track(track),
	.conv_busy(conv_busy)
);

// ===== tb/tb_top.sv
// Bench for the converter control block
`timescale 1ns/10ps
module tb_top;
	logic sys_clk = 1'b0, reset = 1'b1, strobe_n, read_sel, eoc_n, ref_on, track, conv_busy, sel, oe_d = 1'b0;
	logic [13:0] sample_code = 14'h0, result_bus_o, result_bus_oe, bus_w, code;
	logic [13:0] exp_q[$];
	int err_total = 0, n_checks = 0, cyc = 0, seed = 40;
	always #20 sys_clk = ~sys_clk;
	sapr_top dut(
		.sys_clk(sys_clk),
		.reset(reset),
		.strobe_n(strobe_n),
		.read_sel(read_sel),
		.sample_code(sample_code),
		.eoc_n(eoc_n),
		.result_bus_o(result_bus_o),
		.result_bus_oe(result_bus_oe),
		.ref_on(ref_on),
		.track(track),
		.conv_busy(conv_busy)
	);
	sapr_host u_host(
		.sys_clk(sys_clk),
		.result_bus_o(result_bus_o),
		.result_bus_oe(result_bus_oe),
		.strobe_n(strobe_n),
		.read_sel(read_sel),
		.bus_w(bus_w)
	);
	task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic settle;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		oe_d <= result_bus_oe[0];
		if (result_bus_oe[0] === 1'b1 && oe_d === 1'b0) begin
			chk("result", exp_q.pop_front(), bus_w);
		end
		if (cyc == 4000) begin
			err_total++;
			summarize();
		end
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		u_host.pulse(1'b1, 2);
		settle();
		chk("track", 14'h0, 14'(track));
		for (int i = 0; i < 6; i++) begin
			sel = i[0];
			code = 14'($random(seed));
			@(posedge sys_clk) sample_code <= code;
			u_host.pulse(1'b0, 3);
			chk("track_ref", 14'h3, 14'({track, ref_on}));
			exp_q.push_back(code ^ 14'h2000);
			u_host.pulse(sel, 2);
			for (int k = 0; k < 130 && eoc_n !== 1'b0; k++) @(posedge sys_clk);
			settle();
			chk("eoc", 14'h0, 14'(eoc_n));
			chk("ref", 14'(!sel), 14'(ref_on));
			u_host.pulse(1'b1, 4);
			settle();
			chk("oe", 14'h0, result_bus_oe);
		end
		u_host.pulse(1'b0, 3);
		@(posedge sys_clk) reset <= 1'b1;
		@(posedge sys_clk) reset <= 1'b0;
		settle();
		chk("idle", 14'h1, 14'({track, eoc_n}));
		summarize();
	end
endmodule
